// ==== slc_cfg.svh ====
// slc_cfg.svh: command codes, field positions, reset values and timing counts
// for the slope-compensation phase register bank.
// assumes: included by bare name from the design, checker and bench modules.
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH

// ------------------------------------------------------------
// command codes of the management bus
// ------------------------------------------------------------
`define SLC_CMD_SLEW_4PH 8'hD4
`define SLC_CMD_LIMIT_4PH 8'hD5
`define SLC_CMD_SLEW_3PH 8'hD6
`define SLC_CMD_LIMIT_3PH 8'hD7
`define SLC_CMD_SLEW_2PH 8'hD8

// ------------------------------------------------------------
// field layout
// ------------------------------------------------------------
`define SLC_LIMIT_MSB 7
`define SLC_CUR_MSB 5
`define SLC_CUR_LSB 0
`define SLC_CAP_LSB 6
`define SLC_CAP_MSB_WIDE 9
`define SLC_CAP_MSB_4PH 8

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define SLC_RST_WORD 16'h0000
`define SLC_LIMIT_LSB_NS 5
`define SLC_CLK_PERIOD_NS 20

`endif

// ==== slc_host_model.sv ====
// slc_host_model.sv: management host writing and reading the ramp words.
// assumes: shares the bank clock; the bench calls wr, rd and wr_slew.
`timescale 1ns/1ps
`default_nettype none
module slc_host_model (
    input wire logic clk_in,
    output logic [7:0] cmd_code_out,
    output logic wr_en_out,
    output logic [15:0] wr_data_out,
    output logic rd_en_out,
    input wire logic [15:0] rd_data_in
);
    // ------------------------------------------------------------
    // strobed word access, one word per strobe
    // ------------------------------------------------------------
    initial begin
        cmd_code_out = 8'h00;
        wr_en_out = 1'b0;
        wr_data_out = 16'h0000;
        rd_en_out = 1'b0;
    end
    // released lines show the inverse so a stale word is never mistaken for live
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_in);
        cmd_code_out <= c;
        wr_data_out <= d;
        wr_en_out <= 1'b1;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
        cmd_code_out <= ~c;
        wr_data_out <= ~d;
    endtask : wr
    // answer is taken one edge after the strobe edge
    task automatic rd(input logic [7:0] c, output logic [15:0] q);
        @(posedge clk_in);
        cmd_code_out <= c;
        rd_en_out <= 1'b1;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        cmd_code_out <= ~c;
        @(posedge clk_in);
        q = rd_data_in;
    endtask : rd
    // half gain on the sense path halves the ramp seen, so the source code is doubled
    task automatic wr_slew(input logic [7:0] c, input logic [3:0] cap, input logic [5:0] cur, input logic half);
        wr(c, {6'h00, cap, half ? cur << 1 : cur});
    endtask : wr_slew
endmodule : slc_host_model
`default_nettype wire

// ==== slc_phase_regs.sv ====
// slc_phase_regs.sv: slope-compensation ramp registers per active phase count.
// assumes: the bus engine outside decodes a command and hands over one word with
// a one-cycle write or read strobe; phase count and ramp pulses come from the pwm core.
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"
//
// Operation
// - 4-phase ramp time limit: low byte, 5 ns per count.
// - limit expiry stops ramp current source and holds ramp voltage.
// - separate 3-phase ramp time limit: low byte, 5 ns per count.
// - time limit registers: bits 15:8 ignore writes and read zero.
// - 3-phase slew: capacitor code bits 9:6, current code bits 5:0.
// - 2-phase slew: separate register, same capacitor and current fields.
// - slew registers: bits 15:10 ignore writes and read zero.
// - 4-phase slew: capacitor code bits 8:6, current code bits 5:0.
module slc_phase_regs (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic wr_en_in,
    input wire logic [15:0] wr_data_in,
    input wire logic rd_en_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic [2:0] phase_count_in,
    input wire logic ramp_start_in,
    input wire logic ramp_reset_in,
    output logic [3:0] cap_code_out,
    output logic [5:0] cur_code_out,
    output logic set_valid_out,
    output logic ramp_source_on_out,
    output logic ramp_hold_out
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a longest time rounds down to whole cycles, never below one
    function automatic slc_pkg::slc_cycles_t limit_to_cycles(input logic [7:0] cnt);
        logic [15:0] ns;
        logic [15:0] cyc;
        ns = 16'(cnt) * 16'(`SLC_LIMIT_LSB_NS);
        cyc = ns / 16'(`SLC_CLK_PERIOD_NS);
        if (cyc == 16'h0000) begin
            cyc = 16'h0001;
        end
        return cyc[5:0];
    endfunction : limit_to_cycles

    // keeps only the implemented slew bits of a written word
    function automatic logic [9:0] slew_fields(input logic [15:0] w, input logic narrow);
        logic [9:0] f;
        f = w[`SLC_CAP_MSB_WIDE:`SLC_CUR_LSB];
        if (narrow) begin
            f[`SLC_CAP_MSB_WIDE] = 1'b0;
        end
        return f;
    endfunction : slew_fields

    // ------------------------------------------------------------
    // register storage: unimplemented bits are never stored, so they read zero
    // ------------------------------------------------------------
    logic [7:0] limit_4ph_r, limit_4ph_nxt;
    logic [7:0] limit_3ph_r, limit_3ph_nxt;
    logic [8:0] slew_4ph_r, slew_4ph_nxt;
    logic [9:0] slew_3ph_r, slew_3ph_nxt;
    logic [9:0] slew_2ph_r, slew_2ph_nxt;
    logic [15:0] rd_data_nxt;
    logic rd_valid_nxt;

    always_comb begin
        limit_4ph_nxt = limit_4ph_r;
        limit_3ph_nxt = limit_3ph_r;
        slew_4ph_nxt = slew_4ph_r;
        slew_3ph_nxt = slew_3ph_r;
        slew_2ph_nxt = slew_2ph_r;
        if (wr_en_in) begin
            case (cmd_code_in)
                `SLC_CMD_LIMIT_4PH: limit_4ph_nxt = wr_data_in[`SLC_LIMIT_MSB:0];
                `SLC_CMD_LIMIT_3PH: limit_3ph_nxt = wr_data_in[`SLC_LIMIT_MSB:0];
                `SLC_CMD_SLEW_4PH: slew_4ph_nxt = 9'(slew_fields(wr_data_in, 1'b1));
                `SLC_CMD_SLEW_3PH: slew_3ph_nxt = slew_fields(wr_data_in, 1'b0);
                `SLC_CMD_SLEW_2PH: slew_2ph_nxt = slew_fields(wr_data_in, 1'b0);
                default: limit_4ph_nxt = limit_4ph_r; // other codes belong to other blocks
            endcase
        end
    end

    // ------------------------------------------------------------
    // read path: one cycle after the strobe; unknown codes answer zero
    // ------------------------------------------------------------
    always_comb begin
        rd_valid_nxt = rd_en_in;
        rd_data_nxt = 16'h0000;
        if (rd_en_in) begin
            case (cmd_code_in)
                `SLC_CMD_LIMIT_4PH: rd_data_nxt = {8'h00, limit_4ph_r};
                `SLC_CMD_LIMIT_3PH: rd_data_nxt = {8'h00, limit_3ph_r};
                `SLC_CMD_SLEW_4PH: rd_data_nxt = {7'h00, slew_4ph_r};
                `SLC_CMD_SLEW_3PH: rd_data_nxt = {6'h00, slew_3ph_r};
                `SLC_CMD_SLEW_2PH: rd_data_nxt = {6'h00, slew_2ph_r};
                default: rd_data_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            limit_4ph_r <= 8'(`SLC_RST_WORD);
            limit_3ph_r <= 8'(`SLC_RST_WORD);
            slew_4ph_r <= 9'(`SLC_RST_WORD);
            slew_3ph_r <= 10'(`SLC_RST_WORD);
            slew_2ph_r <= 10'(`SLC_RST_WORD);
            rd_data_out <= 16'h0000;
            rd_valid_out <= 1'b0;
        end else begin
            limit_4ph_r <= limit_4ph_nxt;
            limit_3ph_r <= limit_3ph_nxt;
            slew_4ph_r <= slew_4ph_nxt;
            slew_3ph_r <= slew_3ph_nxt;
            slew_2ph_r <= slew_2ph_nxt;
            rd_data_out <= rd_data_nxt;
            rd_valid_out <= rd_valid_nxt;
        end
    end

    // ------------------------------------------------------------
    // set selection by active phase count
    // ------------------------------------------------------------
    slc_pkg::slc_set_e set_r, set_nxt;
    logic [3:0] cap_nxt;
    logic [5:0] cur_nxt;
    logic limit_en_nxt;
    logic limit_en_r;
    slc_pkg::slc_cycles_t limit_cyc_nxt, limit_cyc_r;
    logic set_change;

    always_comb begin
        case (phase_count_in)
            3'h4: set_nxt = slc_pkg::SLC_SET_4PH;
            3'h3: set_nxt = slc_pkg::SLC_SET_3PH;
            3'h2: set_nxt = slc_pkg::SLC_SET_2PH;
            default: set_nxt = slc_pkg::SLC_SET_NONE;
        endcase
        set_change = (set_nxt != set_r);
        cap_nxt = 4'h0;
        cur_nxt = 6'h00;
        limit_en_nxt = 1'b0;
        limit_cyc_nxt = 6'h01;
        case (set_nxt)
            slc_pkg::SLC_SET_4PH: begin
                cap_nxt = {1'b0, slew_4ph_r[`SLC_CAP_MSB_4PH:`SLC_CAP_LSB]};
                cur_nxt = slew_4ph_r[`SLC_CUR_MSB:`SLC_CUR_LSB];
                limit_en_nxt = 1'b1;
                limit_cyc_nxt = limit_to_cycles(limit_4ph_r);
            end
            slc_pkg::SLC_SET_3PH: begin
                cap_nxt = slew_3ph_r[`SLC_CAP_MSB_WIDE:`SLC_CAP_LSB];
                cur_nxt = slew_3ph_r[`SLC_CUR_MSB:`SLC_CUR_LSB];
                limit_en_nxt = 1'b1;
                limit_cyc_nxt = limit_to_cycles(limit_3ph_r);
            end
            slc_pkg::SLC_SET_2PH: begin
                // the 2-phase time limit lives outside this bank, so the ramp is not cut short
                cap_nxt = slew_2ph_r[`SLC_CAP_MSB_WIDE:`SLC_CAP_LSB];
                cur_nxt = slew_2ph_r[`SLC_CUR_MSB:`SLC_CUR_LSB];
            end
            default: begin
                cap_nxt = 4'h0;
                cur_nxt = 6'h00;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            set_r <= slc_pkg::SLC_SET_NONE;
            cap_code_out <= 4'h0;
            cur_code_out <= 6'h00;
            set_valid_out <= 1'b0;
            limit_en_r <= 1'b0;
            limit_cyc_r <= 6'h01;
        end else begin
            set_r <= set_nxt;
            cap_code_out <= cap_nxt;
            cur_code_out <= cur_nxt;
            set_valid_out <= (set_nxt != slc_pkg::SLC_SET_NONE);
            limit_en_r <= limit_en_nxt;
            limit_cyc_r <= limit_cyc_nxt;
        end
    end

    // ------------------------------------------------------------
    // ramp timer: a set change aborts the running ramp so no stale limit applies
    // ------------------------------------------------------------
    slc_ramp_if rif ();

    assign rif.start = ramp_start_in && (set_r != slc_pkg::SLC_SET_NONE);
    assign rif.abort = ramp_reset_in || set_change;
    assign rif.limit_en = limit_en_r;
    assign rif.limit_cycles = limit_cyc_r;

    slc_ramp_timer u_timer (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .rif(rif.timer)
    );

    // timer state registers reach the pins through one more register, to match the set outputs
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ramp_source_on_out <= 1'b0;
            ramp_hold_out <= 1'b0;
        end else begin
            ramp_source_on_out <= rif.source_on;
            ramp_hold_out <= rif.hold;
        end
    end

endmodule : slc_phase_regs
`default_nettype wire

// ==== slc_phase_regs_asserts.sv ====
// slc_phase_regs_asserts.sv: port checks of the slope ramp register bank.
// assumes: bound into slc_phase_regs; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"
module slc_phase_regs_asserts (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic rd_en_in,
    input wire logic [15:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic [2:0] phase_count_in,
    input wire logic ramp_start_in,
    input wire logic ramp_reset_in,
    input wire logic set_valid_out,
    input wire logic ramp_source_on_out,
    input wire logic ramp_hold_out
);
    // ------------------------------------------------------------
    // read answers, set choice and ramp timing
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_lim_rd;
        rd_en_in && cmd_code_in inside {`SLC_CMD_LIMIT_4PH, `SLC_CMD_LIMIT_3PH}
            |=> rd_valid_out && rd_data_out[15:8] == 8'h00;
    endproperty
    a_lim_rd: assert property (p_lim_rd) else $error("limit read high byte");
    property p_slew_rd;
        rd_en_in && cmd_code_in inside {`SLC_CMD_SLEW_3PH, `SLC_CMD_SLEW_2PH}
            |=> rd_valid_out && rd_data_out[15:10] == 6'h00;
    endproperty
    a_slew_rd: assert property (p_slew_rd) else $error("slew read high bits");
    property p_slew4_rd;
        rd_en_in && cmd_code_in == `SLC_CMD_SLEW_4PH |=> rd_valid_out && rd_data_out[15:9] == 7'h00;
    endproperty
    a_slew4_rd: assert property (p_slew4_rd) else $error("4ph slew read high bits");
    // a held ramp must never still be charging
    property p_excl;
        !(ramp_source_on_out && ramp_hold_out);
    endproperty
    a_excl: assert property (p_excl) else $error("source on while held");
    property p_start;
        ramp_start_in && !ramp_reset_in && phase_count_in == 3'h4 && $stable(phase_count_in) && set_valid_out
            && !ramp_source_on_out && !ramp_hold_out && !$past(ramp_reset_in) && !$past(ramp_start_in)
            ##1 !ramp_reset_in && $stable(phase_count_in) |=> ramp_source_on_out;
    endproperty
    a_start: assert property (p_start) else $error("ramp did not start");
    property p_rst_clr;
        ramp_reset_in |=> ##1 !ramp_hold_out && !ramp_source_on_out;
    endproperty
    a_rst_clr: assert property (p_rst_clr) else $error("ramp not cleared");
    property p_set_vld;
        !$past(srst_in) |-> set_valid_out == ($past(phase_count_in) inside {3'h2, 3'h3, 3'h4});
    endproperty
    a_set_vld: assert property (p_set_vld) else $error("set valid wrong");
    // two-phase set has no limit here, so only a reset or set change stops it
    property p_2ph_on;
        ramp_source_on_out && phase_count_in == 3'h2 && $past(phase_count_in) == 3'h2 && !ramp_reset_in
            && !$past(ramp_reset_in) && $past(phase_count_in, 2) == 3'h2 |=> ramp_source_on_out;
    endproperty
    a_2ph_on: assert property (p_2ph_on) else $error("2ph ramp stopped");
    c_rd: cover property (rd_valid_out);
    c_hold: cover property ($rose(ramp_hold_out));
    c_2ph: cover property (ramp_source_on_out && phase_count_in == 3'h2);
endmodule : slc_phase_regs_asserts
bind slc_phase_regs slc_phase_regs_asserts slc_phase_regs_asserts_inst (.clk_in(clk_in), .srst_in(srst_in),
    .cmd_code_in(cmd_code_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .phase_count_in(phase_count_in), .ramp_start_in(ramp_start_in), .ramp_reset_in(ramp_reset_in),
    .set_valid_out(set_valid_out), .ramp_source_on_out(ramp_source_on_out), .ramp_hold_out(ramp_hold_out));
`default_nettype wire

// ==== slc_pkg.sv ====
// slc_pkg.sv: types shared by the register bank and its ramp timer.
// assumes: slc_cfg.svh is on the include path.
package slc_pkg;

    // ------------------------------------------------------------
    // register set selected by the active phase count
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SLC_SET_NONE = 4'h1,
        SLC_SET_2PH = 4'h2,
        SLC_SET_3PH = 4'h4,
        SLC_SET_4PH = 4'h8
    } slc_set_e;

    // ------------------------------------------------------------
    // ramp timer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SLC_RAMP_IDLE = 3'h1,
        SLC_RAMP_RUN = 3'h2,
        SLC_RAMP_HOLD = 3'h4
    } slc_ramp_e;

    typedef logic [5:0] slc_cycles_t;

endpackage : slc_pkg

// ==== slc_ramp_if.sv ====
// slc_ramp_if.sv: carrier between the register bank and the ramp timer.
// assumes: both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface slc_ramp_if;
    logic start;
    logic abort;
    logic limit_en;
    slc_pkg::slc_cycles_t limit_cycles;
    logic source_on;
    logic hold;

    modport bank (output start, output abort, output limit_en, output limit_cycles,
                  input source_on, input hold);
    modport timer (input start, input abort, input limit_en, input limit_cycles,
                   output source_on, output hold);
endinterface : slc_ramp_if
`default_nettype wire

// ==== slc_ramp_timer.sv ====
// slc_ramp_timer.sv: times one slope-compensation ramp and holds it at the limit.
// assumes: start and abort are one-cycle pulses on the common clock.
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"
module slc_ramp_timer (
    input wire logic clk_in,
    input wire logic srst_in,
    slc_ramp_if.timer rif
);

    slc_pkg::slc_ramp_e state_r;
    slc_pkg::slc_ramp_e state_nxt;
    slc_pkg::slc_cycles_t cnt_r;
    slc_pkg::slc_cycles_t cnt_nxt;
    logic expire;

    // ------------------------------------------------------------
    // next state: abort beats start so a phase change never leaves a stale ramp
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        expire = rif.limit_en && ((cnt_r + 6'h01) >= rif.limit_cycles);
        if (rif.abort) begin
            state_nxt = slc_pkg::SLC_RAMP_IDLE;
            cnt_nxt = 6'h00;
        end else begin
            case (state_r)
                slc_pkg::SLC_RAMP_IDLE: begin
                    if (rif.start) begin
                        state_nxt = slc_pkg::SLC_RAMP_RUN;
                        cnt_nxt = 6'h00;
                    end
                end
                slc_pkg::SLC_RAMP_RUN: begin
                    if (expire) begin
                        state_nxt = slc_pkg::SLC_RAMP_HOLD;
                    end else if (cnt_r != 6'h3F) begin
                        cnt_nxt = cnt_r + 6'h01;
                    end
                end
                slc_pkg::SLC_RAMP_HOLD: begin
                    state_nxt = slc_pkg::SLC_RAMP_HOLD; // held until the cycle resets
                end
                default: begin
                    state_nxt = slc_pkg::SLC_RAMP_IDLE;
                    cnt_nxt = 6'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r <= slc_pkg::SLC_RAMP_IDLE;
            cnt_r <= 6'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // source stops and the voltage is held once the limit has run out
    assign rif.source_on = (state_r == slc_pkg::SLC_RAMP_RUN);
    assign rif.hold = (state_r == slc_pkg::SLC_RAMP_HOLD);

endmodule : slc_ramp_timer
`default_nettype wire

// ==== test_slc_phase_regs.sv ====
// test_slc_phase_regs.sv: self-checking bench of the slope ramp register bank.
// assumes: the host model drives the command port; the bench drives phase and ramp pulses.
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"
module test_slc_phase_regs;
    logic clk_in, srst_in, rstart, rreset, wr_en, rd_en, rd_valid, set_valid, src, hold;
    logic [2:0] phase;
    logic [7:0] cmd;
    logic [15:0] wr_data, rd_data, q;
    logic [3:0] cap;
    logic [5:0] cur;
    logic [31:0] d;
    logic [31:0] seed = 32'h0000C2A5;
    logic [15:0] sh [5];
    logic [7:0] cmds [6] = '{`SLC_CMD_SLEW_4PH, `SLC_CMD_LIMIT_4PH, `SLC_CMD_SLEW_3PH, `SLC_CMD_LIMIT_3PH,
        `SLC_CMD_SLEW_2PH, 8'hD9};
    logic [15:0] masks [5] = '{16'h01FF, 16'h00FF, 16'h03FF, 16'h00FF, 16'h03FF};
    int k;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    slc_host_model slc_host_model_inst (.clk_in(clk_in), .cmd_code_out(cmd), .wr_en_out(wr_en),
        .wr_data_out(wr_data), .rd_en_out(rd_en), .rd_data_in(rd_data));
    slc_phase_regs slc_phase_regs_inst (.clk_in(clk_in), .srst_in(srst_in), .cmd_code_in(cmd), .wr_en_in(wr_en),
        .wr_data_in(wr_data), .rd_en_in(rd_en), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .phase_count_in(phase), .ramp_start_in(rstart), .ramp_reset_in(rreset), .cap_code_out(cap),
        .cur_code_out(cur), .set_valid_out(set_valid), .ramp_source_on_out(src), .ramp_hold_out(hold));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // active set as {set_valid, cap, cur}; the 4ph cap is zero-extended by its mask
    function automatic logic [31:0] exp_set(input logic [2:0] ph);
        case (ph)
            3'h4: return {21'h0, 1'b1, sh[0][9:0]};
            3'h3: return {21'h0, 1'b1, sh[2][9:0]};
            3'h2: return {21'h0, 1'b1, sh[4][9:0]};
            default: return 32'h0;
        endcase
    endfunction : exp_set
    // on-time in clocks, rounded down, never below one for 3ph and 4ph; 2ph runs to the loop ceiling, other counts give zero
    function automatic int exp_on(input logic [2:0] ph, input logic [7:0] c);
        int t;
        t = int'(c) * `SLC_LIMIT_LSB_NS / `SLC_CLK_PERIOD_NS;
        if (ph == 3'h2) return 70;
        if (ph != 3'h3 && ph != 3'h4) return 0;
        return (t == 0) ? 1 : t;
    endfunction : exp_on
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // one ramp: load limit, select set, start, time the source, then discharge
    task automatic ramp(input logic [2:0] ph, input logic [7:0] c);
        int n;
        int m;
        if (ph == 3'h4) slc_host_model_inst.wr(`SLC_CMD_LIMIT_4PH, {8'h00, c});
        if (ph == 3'h3) slc_host_model_inst.wr(`SLC_CMD_LIMIT_3PH, {8'h00, c});
        @(posedge clk_in);
        phase <= ph;
        repeat (3) @(posedge clk_in);
        chk("set codes", exp_set(ph), {set_valid, cap, cur});
        rstart <= 1'b1;
        @(posedge clk_in);
        rstart <= 1'b0;
        n = 0;
        while (src !== 1'b1 && n < 5) begin
            @(posedge clk_in);
            n++;
        end
        chk("ramp rise", (exp_on(ph, c) > 0) ? 2 : 5, n);
        m = 0;
        while (src === 1'b1 && m < 70) begin
            @(posedge clk_in);
            m++;
        end
        chk("ramp on time", exp_on(ph, c), m);
        chk("ramp hold", ph == 3'h3 || ph == 3'h4, hold);
        rreset <= 1'b1;
        @(posedge clk_in);
        rreset <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk("ramp cleared", 0, {src, hold});
    endtask : ramp
    // ------------------------------------------------------------
    // clock, hang guard and main sequence
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // the whole run needs under 2000 clocks
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        srst_in = 1'b1;
        phase = 3'h0;
        rstart = 1'b0;
        rreset = 1'b0;
        for (k = 0; k < 5; k++) sh[k] = 16'h0000;
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        chk("reset outputs", 32'h0, {rd_data, rd_valid, cap, cur, set_valid, src, hold});
        // all-ones first on every code, then random words and codes
        for (int i = 0; i < 30; i++) begin
            d = (i < 6) ? 32'h0000FFFF : xs();
            k = (i < 6) ? i : int'(xs() % 6);
            slc_host_model_inst.wr(cmds[k], d[15:0]);
            if (k < 5) sh[k] = d[15:0] & masks[k];
            slc_host_model_inst.rd(cmds[k], q);
            chk("read word", (k < 5) ? sh[k] : 16'h0000, q);
        end
        slc_host_model_inst.wr_slew(`SLC_CMD_SLEW_2PH, 4'hA, 6'h11, 1'b1);
        sh[4] = 16'h02A2;
        ramp(3'h4, 8'h08);
        ramp(3'h4, 8'h00);
        ramp(3'h3, 8'hFF);
        ramp(3'h2, 8'h10);
        ramp(3'h5, 8'h10);
        for (int i = 0; i < 8; i++) begin
            d = xs();
            ramp(d[8] ? 3'h4 : 3'h3, d[7:0]);
        end
        // mid-run reset: every word and every output must return to zero
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        chk("reset again", 32'h0, {rd_data, rd_valid, cap, cur, set_valid, src, hold});
        for (k = 0; k < 5; k++) begin
            slc_host_model_inst.rd(cmds[k], q);
            chk("reset word", 32'h0, q);
        end
        end_of_test();
    end
endmodule : test_slc_phase_regs
`default_nettype wire
